/* rtcui_pkg.sv */
// Constants shared by the update and alarm interrupt block.
`default_nettype none
package rtcui_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] SECONDS_ADDR = 8'h00;
  localparam logic [7:0] MIN_ALM_ADDR = 8'h07;
  localparam logic [7:0] HOUR_ALM_ADDR = 8'h08;
  localparam logic [7:0] DAY_ALM_ADDR = 8'h09;
  localparam logic [7:0] FLAGS_ADDR = 8'h0e;
  localparam logic [7:0] CTRL1_ADDR = 8'h0f;
  localparam logic [7:0] CTRL2_ADDR = 8'h10;
  localparam logic [7:0] COMASK_ADDR = 8'h12;
  // ==========================================
  // Field positions
  localparam int unsigned ALM_DIS_BIT = 7;
  localparam int unsigned AF_BIT = 3;
  localparam int unsigned UF_BIT = 4;
  localparam int unsigned UPDATE_PERIOD_SELECT_BIT = 4;
  localparam int unsigned WEEKDAY_OR_DATE_SELECT_BIT = 5;
  localparam int unsigned AIE_BIT = 3;
  localparam int unsigned UIE_BIT = 5;
  localparam int unsigned IRQ_CLOCK_OUT_ENABLE_BIT = 6;
  localparam int unsigned ALARM_CLOCK_OUT_ENABLE_BIT = 3;
  localparam int unsigned UPDATE_CLOCK_OUT_ENABLE_BIT = 4;
  // ==========================================
  // Reset values
  localparam logic [7:0] ALM_RESET = 8'h80;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] FD_OFF = 3'h7;
  // ==========================================
  // Time base and timing
  localparam logic [5:0] TICK_MAX = 6'h3f;
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] BCD_TEN = 6'h0a;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned REL_SEC_US = 500000;
  localparam int unsigned REL_MIN_US = 7813;
  localparam int unsigned REL_SEC_CYC = REL_SEC_US * CLK_MHZ;
  localparam int unsigned REL_MIN_CYC = REL_MIN_US * CLK_MHZ;
  localparam int unsigned REL_W = 27;
endpackage
`default_nettype wire

/* rtcui_ub_if.sv */
// Carrier between the register logic and the update event generator.
`default_nettype none
interface rtcui_ub_if;
  logic restart;
  logic sec_load;
  logic [5:0] sec_val;
  logic period_sel;
  logic evt;
  modport ctl(output restart, output sec_load, output sec_val, output period_sel, input evt);
  modport gen(input restart, input sec_load, input sec_val, input period_sel, output evt);
endinterface
`default_nettype wire

/* rtcui_update_gen.sv */
// Update event generator: sub-second prescaler and seconds counter.
`default_nettype none
module rtcui_update_gen (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_tick_64hz,
  rtcui_ub_if.gen ub
);
  logic [5:0] subsec_reg;
  logic [5:0] subsec_next;
  logic [5:0] sec_reg;
  logic [5:0] sec_next;
  logic evt_reg;
  logic evt_next;
  wire sec_edge;
  wire min_edge;

  // ==========================================
  // Boundary detection
  // The generator never stops; only the pin path is gated elsewhere.
  assign sec_edge = i_tick_64hz & (subsec_reg == rtcui_pkg::TICK_MAX); // R7
  assign min_edge = sec_edge & (sec_reg == rtcui_pkg::SEC_MAX);
  // A restart clears the prescaler, so the current period is stretched.
  assign subsec_next = ub.restart ? 6'h00 : (i_tick_64hz ? 6'(subsec_reg + 6'h01) : subsec_reg); // R9 R18
  assign sec_next = ub.sec_load ? ub.sec_val :
                    (sec_edge ? (min_edge ? 6'h00 : 6'(sec_reg + 6'h01)) : sec_reg);
  assign evt_next = ~ub.restart & (ub.period_sel ? min_edge : sec_edge); // R1
  assign ub.evt = evt_reg;

  // Counters and event pulse register.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      subsec_reg <= 6'h00;
      sec_reg <= 6'h00;
      evt_reg <= 1'b0;
    end else begin
      subsec_reg <= subsec_next;
      sec_reg <= sec_next;
      evt_reg <= evt_next;
    end
  end

  // ==========================================
  // Checks
  a_second_event: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R1
    (sec_edge && !ub.period_sel && !ub.restart) |=> evt_reg)
    else $error("second boundary gave no update event");
  a_minute_only: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R1
    (ub.period_sel && !min_edge) |=> !evt_reg)
    else $error("minute mode event off a minute boundary");
endmodule
`default_nettype wire

/* rtcui_top.sv */
// Update and alarm interrupt block of the real-time clock.
//
// Contract
// [R1] Update event every second, or every minute when period select is set.
// [R2] Each update event sets the update flag; it stays until software clears it.
// [R3] Interrupt pin goes low on update event only when update enable is set.
// [R4] Pin released after 500 ms in second mode or 7.813 ms in minute mode.
// [R5] Clearing the update flag releases the pin at once.
// [R6] Clearing the update enable releases the pin at once.
// [R7] Update events keep running; the enable only gates the pin.
// [R8] Update pulse turns clock output on when its enables allow it.
// [R9] Reset bit write or seconds write alters the running update period.
// [R10] First update event comes at the next boundary, never at once.
// [R11] Host clears update enable and flag before changing update settings.
// [R12] Alarm match sets the alarm flag; pin low only with alarm enable.
// [R13] Alarm signal turns clock output on when its enables allow it.
// [R14] Day alarm compares weekday when select is 0, date when 1.
// [R15] Minutes, hours, day compared with alarm bytes at 07h to 09h.
// [R16] Each disable bit removes its field from the comparison.
// [R17] All three disables set, the reset default, gives no alarms.
// [R18] Reset bit write or seconds write shifts the next alarm time.
// [R19] Host using byte 07h as storage keeps alarm enable at 0.
// [R20] Host clears alarm enable and flag before changing alarm settings.
// [R21] An alarm fires once, when the counters move into the match; here any counter change while matching fires.
// [R22] Alarm holds pin low while flag and enable set; pin ORs sources.
`default_nettype none
module rtcui_top #(
  parameter int unsigned REL_SEC_CYCLES = rtcui_pkg::REL_SEC_CYC,
  parameter int unsigned REL_MIN_CYCLES = rtcui_pkg::REL_MIN_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_reset_bit_wr,
  input wire logic i_tick_64hz,
  input wire logic [6:0] i_minute_cnt,
  input wire logic [5:0] i_hour_cnt,
  input wire logic [2:0] i_weekday_cnt,
  input wire logic [5:0] i_date_cnt,
  input wire logic i_free_clock_out_enable,
  input wire logic [2:0] i_clock_out_freq_select,
  output logic o_int_n,
  output logic o_clkout_on
);
  // ==========================================
  // Declarations
  logic [7:0] min_alm_reg;
  logic [7:0] hour_alm_reg;
  logic [7:0] day_alm_reg;
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] comask_reg;
  logic update_flag_reg;
  logic update_flag_next;
  logic alarm_flag_reg;
  logic alarm_flag_next;
  logic upd_hold_reg;
  logic upd_hold_next;
  logic [rtcui_pkg::REL_W-1:0] rel_cnt_reg;
  logic [rtcui_pkg::REL_W-1:0] rel_cnt_next;
  logic [21:0] time_prev_reg;
  logic time_valid_reg;
  logic int_n_reg;
  logic clkout_reg;
  logic [7:0] rdata_reg;
  rtcui_ub_if ub();

  // ==========================================
  // Address decode
  wire wr_sec = i_reg_wr & (i_reg_addr == rtcui_pkg::SECONDS_ADDR);
  wire wr_min_alm = i_reg_wr & (i_reg_addr == rtcui_pkg::MIN_ALM_ADDR);
  wire wr_hour_alm = i_reg_wr & (i_reg_addr == rtcui_pkg::HOUR_ALM_ADDR);
  wire wr_day_alm = i_reg_wr & (i_reg_addr == rtcui_pkg::DAY_ALM_ADDR);
  wire wr_flags = i_reg_wr & (i_reg_addr == rtcui_pkg::FLAGS_ADDR);
  wire wr_ctrl1 = i_reg_wr & (i_reg_addr == rtcui_pkg::CTRL1_ADDR);
  wire wr_ctrl2 = i_reg_wr & (i_reg_addr == rtcui_pkg::CTRL2_ADDR);
  wire wr_comask = i_reg_wr & (i_reg_addr == rtcui_pkg::COMASK_ADDR);

  // ==========================================
  // Control fields
  wire update_period_select = ctrl1_reg[rtcui_pkg::UPDATE_PERIOD_SELECT_BIT];
  wire weekday_or_date_select = ctrl1_reg[rtcui_pkg::WEEKDAY_OR_DATE_SELECT_BIT];
  wire update_irq_enable = ctrl2_reg[rtcui_pkg::UIE_BIT];
  wire alarm_irq_enable = ctrl2_reg[rtcui_pkg::AIE_BIT];
  wire irq_clock_out_enable = ctrl2_reg[rtcui_pkg::IRQ_CLOCK_OUT_ENABLE_BIT];
  wire update_clock_out_enable = comask_reg[rtcui_pkg::UPDATE_CLOCK_OUT_ENABLE_BIT];
  wire alarm_clock_out_enable = comask_reg[rtcui_pkg::ALARM_CLOCK_OUT_ENABLE_BIT];
  wire minute_alarm_disable = min_alm_reg[rtcui_pkg::ALM_DIS_BIT];
  wire hour_alarm_disable = hour_alm_reg[rtcui_pkg::ALM_DIS_BIT];
  wire day_alarm_disable = day_alm_reg[rtcui_pkg::ALM_DIS_BIT];

  // ==========================================
  // Update event generator
  // A write of the reset bit or the seconds register restarts the period.
  assign ub.restart = i_reset_bit_wr | wr_sec; // R9 R18
  assign ub.sec_load = wr_sec;
  assign ub.sec_val = 6'(6'(i_reg_wdata[6:4]) * rtcui_pkg::BCD_TEN) + 6'(i_reg_wdata[3:0]);
  assign ub.period_sel = update_period_select; // R1

  rtcui_update_gen u_gen (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_tick_64hz(i_tick_64hz),
    .ub(ub)
  );

  // Events only come from boundaries, so enabling never fires at once.
  wire update_event_pulse = ub.evt; // R10

  // ==========================================
  // Update flag
  // Hardware set wins over a clear written in the same cycle.
  wire uf_clear = wr_flags & ~i_reg_wdata[rtcui_pkg::UF_BIT];
  assign update_flag_next = update_event_pulse | (update_flag_reg & ~uf_clear); // R2 R7

  // ==========================================
  // Update pin hold and auto release
  // The release length is latched at the event, so a period select change
  // while the pin is low does not alter the current low time.
  wire [rtcui_pkg::REL_W-1:0] rel_load = update_period_select ?
    rtcui_pkg::REL_W'(REL_MIN_CYCLES - 1) : rtcui_pkg::REL_W'(REL_SEC_CYCLES - 1); // R4
  wire upd_start = update_event_pulse & update_irq_enable; // R3
  wire upd_kill = ~update_flag_reg | ~update_irq_enable; // R5 R6
  wire rel_done = (rel_cnt_reg == '0);
  assign upd_hold_next = upd_start ? 1'b1 :
                         ((upd_kill | rel_done) ? 1'b0 : upd_hold_reg); // R4 R5 R6
  assign rel_cnt_next = upd_start ? rel_load :
                        ((upd_hold_reg & ~rel_done) ? rtcui_pkg::REL_W'(rel_cnt_reg - 1'b1) : rel_cnt_reg);

  // ==========================================
  // Alarm comparison
  wire [5:0] day_now = weekday_or_date_select ? i_date_cnt : {3'h0, i_weekday_cnt}; // R14
  wire minute_ok = minute_alarm_disable | (min_alm_reg[6:0] == i_minute_cnt); // R15 R16
  wire hour_ok = hour_alarm_disable | (hour_alm_reg[5:0] == i_hour_cnt); // R15 R16
  wire day_ok = day_alarm_disable | (day_alm_reg[5:0] == day_now); // R15 R16
  wire all_disabled = minute_alarm_disable & hour_alarm_disable & day_alarm_disable; // R17
  wire alarm_match = ~all_disabled & minute_ok & hour_ok & day_ok; // R15 R17

  // Only a move of the time counters can fire, so holding a match or
  // rewriting alarm bytes raises nothing further.
  wire [21:0] time_now = {i_minute_cnt, i_hour_cnt, i_weekday_cnt, i_date_cnt};
  wire time_moved = time_valid_reg & (time_now != time_prev_reg); // R21
  wire alarm_event_signal = alarm_match & time_moved; // R21

  // ==========================================
  // Alarm flag
  wire af_clear = wr_flags & ~i_reg_wdata[rtcui_pkg::AF_BIT];
  assign alarm_flag_next = alarm_event_signal | (alarm_flag_reg & ~af_clear); // R12

  // ==========================================
  // Pin and clock output
  wire alarm_pin_low = alarm_flag_reg & alarm_irq_enable; // R12 R22
  wire int_low = upd_hold_reg | alarm_pin_low; // R22
  // The clock output is only switched when the free-running output is off
  // and a frequency is chosen; otherwise the source has no effect on it.
  wire co_allowed = irq_clock_out_enable & ~i_free_clock_out_enable &
                    (i_clock_out_freq_select != rtcui_pkg::FD_OFF);
  wire co_update = update_clock_out_enable & upd_hold_reg; // R8
  wire co_alarm = alarm_clock_out_enable & alarm_pin_low; // R13
  wire clkout_next = co_allowed & (co_update | co_alarm); // R8 R13

  // ==========================================
  // Read multiplexer
  wire [7:0] flags_rd = (8'(update_flag_reg) << rtcui_pkg::UF_BIT) |
                        (8'(alarm_flag_reg) << rtcui_pkg::AF_BIT);
  wire [7:0] rd_mux =
    (i_reg_addr == rtcui_pkg::MIN_ALM_ADDR) ? min_alm_reg :
    (i_reg_addr == rtcui_pkg::HOUR_ALM_ADDR) ? hour_alm_reg :
    (i_reg_addr == rtcui_pkg::DAY_ALM_ADDR) ? day_alm_reg :
    (i_reg_addr == rtcui_pkg::FLAGS_ADDR) ? flags_rd :
    (i_reg_addr == rtcui_pkg::CTRL1_ADDR) ? ctrl1_reg :
    (i_reg_addr == rtcui_pkg::CTRL2_ADDR) ? ctrl2_reg :
    (i_reg_addr == rtcui_pkg::COMASK_ADDR) ? comask_reg : 8'h00;

  // ==========================================
  // Software registers
  // Alarm bytes reset with their field excluded, so no alarm can fire.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      min_alm_reg <= rtcui_pkg::ALM_RESET; // R17
      hour_alm_reg <= rtcui_pkg::ALM_RESET; // R17
      day_alm_reg <= rtcui_pkg::ALM_RESET; // R17
      ctrl1_reg <= rtcui_pkg::CTRL_RESET;
      ctrl2_reg <= rtcui_pkg::CTRL_RESET;
      comask_reg <= rtcui_pkg::CTRL_RESET;
    end else begin
      if (wr_min_alm) begin
        min_alm_reg <= i_reg_wdata;
      end
      if (wr_hour_alm) begin
        hour_alm_reg <= i_reg_wdata;
      end
      if (wr_day_alm) begin
        day_alm_reg <= i_reg_wdata;
      end
      if (wr_ctrl1) begin
        ctrl1_reg <= i_reg_wdata;
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= i_reg_wdata;
      end
      if (wr_comask) begin
        comask_reg <= i_reg_wdata;
      end
    end
  end

  // Flags, hold timer and previous time sample.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      update_flag_reg <= 1'b0;
      alarm_flag_reg <= 1'b0;
      upd_hold_reg <= 1'b0;
      rel_cnt_reg <= '0;
      time_prev_reg <= 22'h000000;
      time_valid_reg <= 1'b0;
    end else begin
      update_flag_reg <= update_flag_next;
      alarm_flag_reg <= alarm_flag_next;
      upd_hold_reg <= upd_hold_next;
      rel_cnt_reg <= rel_cnt_next;
      time_prev_reg <= time_now;
      time_valid_reg <= 1'b1;
    end
  end

  // Output flops; the pin idles high.
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      int_n_reg <= 1'b1;
      clkout_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      int_n_reg <= ~int_low; // R3 R22
      clkout_reg <= clkout_next;
      rdata_reg <= rd_mux;
    end
  end

  assign o_int_n = int_n_reg;
  assign o_clkout_on = clkout_reg;
  assign o_reg_rdata = rdata_reg;

  // ==========================================
  // Checks
  // Update flag: set by each event, cleared only by a written zero.
  a_update_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R2
    update_event_pulse |=> update_flag_reg)
    else $error("update event did not set the flag");

  a_update_flag_sticky: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R2
    (update_flag_reg && !uf_clear) |=> update_flag_reg)
    else $error("update flag dropped without a clear");

  a_update_flag_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R2
    (uf_clear && !update_event_pulse) |=> !update_flag_reg)
    else $error("update flag survived a clear write");

  // Update pin: started by an enabled event, ended by time, flag or enable.
  a_update_pin_low: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
    (update_event_pulse && update_irq_enable) |=> upd_hold_reg ##1 !o_int_n)
    else $error("enabled update event did not pull the pin low");

  a_update_gated: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R3
    (!update_irq_enable) |=> !upd_hold_reg)
    else $error("update hold set while disabled");

  // The length comes from the mode in force at the event.
  a_release_load: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
    $rose(upd_hold_reg) |-> rel_cnt_reg == ($past(update_period_select) ?
      rtcui_pkg::REL_W'(REL_MIN_CYCLES - 1) : rtcui_pkg::REL_W'(REL_SEC_CYCLES - 1)))
    else $error("auto release length wrong for the period mode");

  a_release_hold: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
    (upd_hold_reg && !rel_done && !upd_kill) |=> upd_hold_reg)
    else $error("pin released before the auto release time");

  a_release_end: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R4
    (upd_hold_reg && rel_done && !upd_start) |=> !upd_hold_reg)
    else $error("pin hold outlived the auto release time");

  a_flag_clear_release: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R5
    (upd_hold_reg && !update_flag_reg && !upd_start) |=> !upd_hold_reg)
    else $error("clearing the update flag did not release the pin");

  a_enable_clear_release: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R6
    (upd_hold_reg && !update_irq_enable) |=> !upd_hold_reg ##1 (o_int_n || $past(alarm_pin_low)))
    else $error("clearing the update enable did not release the pin");

  // A restart must not fire, or a seconds write could end a period early.
  a_restart_no_event: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R9
    ub.restart |=> !update_event_pulse)
    else $error("update event in the cycle after a restart");

  // Alarm flag and pin.
  a_alarm_flag_set: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R12
    alarm_event_signal |=> alarm_flag_reg)
    else $error("alarm match did not set the flag");

  a_alarm_flag_sticky: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R12
    (alarm_flag_reg && !af_clear) |=> alarm_flag_reg)
    else $error("alarm flag dropped without a clear");

  a_alarm_flag_clear: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R12
    (af_clear && !alarm_event_signal) |=> !alarm_flag_reg)
    else $error("alarm flag survived a clear write");

  a_alarm_pin: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R22
    (alarm_flag_reg && alarm_irq_enable) |=> !o_int_n)
    else $error("alarm flag with enable did not hold the pin low");

  // The shared pin is low only while some source holds it.
  a_pin_idle: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R22
    (!upd_hold_reg && !alarm_pin_low) |=> o_int_n)
    else $error("pin low with no active source");

  // The reset default of the alarm bytes keeps the alarm silent.
  a_all_disabled: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R17
    all_disabled |-> !alarm_event_signal)
    else $error("alarm fired with every field excluded");

  // A held match stays silent; only a time change can fire.
  a_alarm_once: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R21
    $stable(time_now) |-> !alarm_event_signal)
    else $error("alarm fired without a change of time");

  // Clock output request, one cycle behind its sources.
  a_clkout_cause: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R8 R13
    o_clkout_on |-> $past(co_allowed) && ($past(co_update) || $past(co_alarm)))
    else $error("clock output on without an enabled source");

  a_clkout_on: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R8 R13
    (co_allowed && (co_update || co_alarm)) |=> o_clkout_on)
    else $error("enabled source did not switch the clock output on");

  // The free-running output or no frequency blocks every source.
  a_clkout_off: assert property (@(posedge i_mclk) disable iff (!i_rstn) // R8 R13
    (!co_allowed) |=> !o_clkout_on)
    else $error("clock output on while blocked");
endmodule
`default_nettype wire

/* rtcui_host.sv */
// Host processor model: byte writes and reads on the decoded register bus.
`default_nettype none
module rtcui_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Idle state
  // The address rests on the flags so the bench can watch them every cycle.
  initial begin
    o_addr = rtcui_pkg::FLAGS_ADDR;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // ==========================================
  // Bus cycles
  // One byte write; the strobe covers exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_mclk);
    o_wr = 1'b0;
    o_addr = rtcui_pkg::FLAGS_ADDR;
    o_wdata = ~d; // Released data never repeats the last value.
  endtask
  // Read data is registered, so it is taken one cycle after the address.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_addr = a;
    @(negedge i_mclk);
    d = i_rdata;
    o_addr = rtcui_pkg::FLAGS_ADDR;
  endtask
  // Both sources are silenced before new settings, or a stale flag could pull the pin.
  task automatic setup(input logic [7:0] c1, input logic [7:0] mask);
    wr(rtcui_pkg::CTRL2_ADDR, 8'h00);
    wr(rtcui_pkg::FLAGS_ADDR, 8'h00);
    wr(rtcui_pkg::CTRL1_ADDR, c1);
    wr(rtcui_pkg::COMASK_ADDR, mask);
  endtask
endmodule
`default_nettype wire

/* test_rtcui_update_and_alarm_irq.sv */
// Self-checking bench for the update and alarm interrupt block.
`default_nettype none
module test_rtc_update_and_alarm_irq;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REL_S = 40;
  localparam int REL_M = 12;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rv, alm_min;
  logic i_reg_wr, o_int_n, o_clkout_on;
  logic i_reset_bit_wr = 1'b0;
  logic i_tick_64hz = 1'b0;
  logic [6:0] i_minute_cnt = 7'h00;
  logic [5:0] i_hour_cnt = 6'h00;
  logic [2:0] i_weekday_cnt = 3'h0;
  logic [5:0] i_date_cnt = 6'h01;
  logic i_free_clock_out_enable = 1'b0;
  logic [2:0] i_clock_out_freq_select = 3'h0;
  logic tick_en = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [7:0] avals [4];
  logic [7:0] reg_q [$] = '{8'h07, 8'h08, 8'h09, 8'h0e, 8'h0f, 8'h10, 8'h12, 8'h05};
  logic [7:0] rst_q [$] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int num_errors = 0;
  int checks_done = 0;
  int ticks = 0;
  int n;
  rtcui_top #(.REL_SEC_CYCLES(REL_S), .REL_MIN_CYCLES(REL_M)) dut_u (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_reset_bit_wr(i_reset_bit_wr),
    .i_tick_64hz(i_tick_64hz), .i_minute_cnt(i_minute_cnt), .i_hour_cnt(i_hour_cnt),
    .i_weekday_cnt(i_weekday_cnt), .i_date_cnt(i_date_cnt), .i_free_clock_out_enable(i_free_clock_out_enable),
    .i_clock_out_freq_select(i_clock_out_freq_select), .o_int_n(o_int_n), .o_clkout_on(o_clkout_on));
  rtcui_host host_u (.i_mclk(i_mclk), .i_rdata(o_reg_rdata), .o_addr(i_reg_addr), .o_wr(i_reg_wr),
    .o_wdata(i_reg_wdata));
  // ==========================================
  // Clock and time base
  always #2.5 i_mclk = ~i_mclk;
  // A tick every fourth cycle keeps flag arrival clear of tick edges when counting.
  always @(negedge i_mclk) begin
    phase <= phase + 2'h1;
    i_tick_64hz <= tick_en && (phase == 2'h0);
    if (tick_en && (phase == 2'h0)) ticks++;
  end
  // ==========================================
  // Model and compare tasks
  // Ticks from a cleared prescaler to the next update event.
  function automatic int ticks_to_event(input int sec, input bit minute);
    return minute ? (60 - sec) * 64 : 64;
  endfunction
  task automatic chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // Runs the time base until a flag bit shows; n holds the ticks it took.
  task automatic wait_flag(input int b, input int lim);
    int t0;
    t0 = ticks;
    tick_en <= 1'b1;
    // Read data lags a flag clear by one cycle.
    @(negedge i_mclk);
    while (o_reg_rdata[b] !== 1'b1 && ticks - t0 <= lim) @(negedge i_mclk);
    n = ticks - t0;
  endtask
  task automatic low_len();
    n = 0;
    while (o_int_n === 1'b0 && n < 300) begin
      @(negedge i_mclk);
      n++;
    end
  endtask
  task automatic set_time(input logic [6:0] mi, input logic [5:0] hr, input logic [2:0] wd, input logic [5:0] dt);
    @(negedge i_mclk);
    i_minute_cnt = mi;
    i_hour_cnt = hr;
    i_weekday_cnt = wd;
    i_date_cnt = dt;
    repeat (6) @(negedge i_mclk);
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  // ==========================================
  // Scenarios
  initial begin
    rv = 8'($urandom(32'hd331087a));
    alm_min = {1'b0, 3'(($urandom % 5) + 1), 4'($urandom % 10)};
    avals = '{alm_min, 8'h12, 8'h03, 8'h21};
    repeat (20) @(negedge i_mclk);
    i_rstn = 1'b1;
    foreach (reg_q[i]) begin
      host_u.rd(reg_q[i], rv);
      chk_reg("reset value", rst_q[i], rv);
    end
    // The minute alarm byte as plain storage, with the alarm enable kept off.
    rv = 8'($urandom) & 8'h7f;
    host_u.wr(8'h07, rv);
    host_u.rd(8'h07, alm_min[7:0]);
    chk_reg("storage byte", rv, alm_min);
    alm_min = avals[0];
    // Second mode after a mid-period restart from the reset bit.
    host_u.setup(8'h00, 8'h10);
    host_u.wr(8'h10, 8'h60);
    tick_en <= 1'b1;
    repeat (80) @(negedge i_mclk);
    tick_en <= 1'b0;
    @(negedge i_mclk);
    i_reset_bit_wr = 1'b1;
    @(negedge i_mclk);
    i_reset_bit_wr = 1'b0;
    wait_flag(4, 80);
    chk_rng("ticks to second event", ticks_to_event(0, 0), ticks_to_event(0, 0), n);
    chk_reg("pin at update", 8'h00, {7'h0, o_int_n});
    chk_reg("clock out at update", 8'h01, {7'h0, o_clkout_on});
    low_len();
    chk_rng("pin low cycles, second mode", REL_S - 3, REL_S + 1, n);
    chk_reg("flags after release", 8'h10, o_reg_rdata);
    // Early release by flag clear, then by enable clear.
    for (int k = 0; k < 2; k++) begin
      host_u.wr(8'h0e, 8'h00);
      wait_flag(4, 80);
      chk_rng("ticks to next event", 1, 64, n);
      host_u.wr(k == 1 ? 8'h10 : 8'h0e, 8'h00);
      repeat (2) @(negedge i_mclk);
      chk_reg("pin after clear", 8'h01, {7'h0, o_int_n});
    end
    host_u.wr(8'h0e, 8'h00);
    wait_flag(4, 80);
    chk_reg("flag with enable off", 8'h10, o_reg_rdata);
    chk_reg("pin with enable off", 8'h01, {7'h0, o_int_n});
    // Minute mode after a seconds write, with no frequency chosen.
    tick_en <= 1'b0;
    i_clock_out_freq_select = 3'h7;
    host_u.setup(8'h10, 8'h10);
    host_u.wr(8'h10, 8'h60);
    host_u.wr(8'h00, 8'h58);
    wait_flag(4, 200);
    chk_rng("ticks to minute event", ticks_to_event(58, 1), ticks_to_event(58, 1), n);
    chk_reg("clock out with no frequency", 8'h00, {7'h0, o_clkout_on});
    low_len();
    chk_rng("pin low cycles, minute mode", REL_M - 3, REL_M + 1, n);
    tick_en <= 1'b0;
    i_clock_out_freq_select = 3'h0;
    // Alarm: nothing with every field excluded, then one field at a time.
    host_u.setup(8'h00, 8'h08);
    host_u.wr(8'h07, 8'h80);
    host_u.wr(8'h10, 8'h48);
    set_time(7'h33, 6'h12, 3'h3, 6'h21);
    chk_reg("flags with all fields off", 8'h00, o_reg_rdata);
    for (int k = 0; k < 4; k++) begin
      set_time(7'h00, 6'h00, 3'h0, 6'h01);
      host_u.setup({2'b00, k == 3, 5'h00}, 8'h08);
      host_u.wr(8'h07, 8'h80);
      host_u.wr(8'h08, 8'h80);
      host_u.wr(8'h09, 8'h80);
      host_u.wr(k == 0 ? 8'h07 : (k == 1 ? 8'h08 : 8'h09), avals[k]);
      host_u.wr(8'h10, 8'h48);
      i_free_clock_out_enable = (k == 1);
      set_time(7'h00, 6'h00, 3'h3, 6'h01);
      chk_reg("flags before match", k == 2 ? 8'h08 : 8'h00, o_reg_rdata);
      set_time(k == 0 ? alm_min[6:0] : 7'h00, k == 1 ? 6'h12 : 6'h00, 3'h3, k == 3 ? 6'h21 : 6'h01);
      repeat (20) @(negedge i_mclk);
      chk_reg("alarm flag on match", 8'h08, o_reg_rdata);
      chk_reg("pin on alarm", 8'h00, {7'h0, o_int_n});
      chk_reg("clock out on alarm", k == 1 ? 8'h00 : 8'h01, {7'h0, o_clkout_on});
      host_u.wr(8'h0e, 8'h00);
      repeat (6) @(negedge i_mclk);
      chk_reg("flags with match held", 8'h00, o_reg_rdata);
      chk_reg("pin after alarm clear", 8'h01, {7'h0, o_int_n});
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
